// [core/lhc_pkg.sv]
// Shared constants and types for the level-2 linefill and hazard controller
`default_nettype none
package lhc_pkg;
	// Control bit positions inside the two control words
	localparam int unsigned LHC_DBL_FILL_BIT = 30;
	localparam int unsigned LHC_HP_READ_BIT  = 10;
	localparam int unsigned LHC_CTRL_W       = 32;
	localparam logic        LHC_CTRL_RESET   = 1'b0;
	// Address and data geometry
	localparam int unsigned LHC_ADDR_W   = 32;
	localparam int unsigned LHC_LINE_LSB = 5;
	localparam int unsigned LHC_LINE_W   = LHC_ADDR_W - LHC_LINE_LSB;
	localparam int unsigned LHC_DATA_W   = 64;
	localparam logic [31:0] LHC_LINE_BYTES = 32'h0000_0020;
	// Burst shapes toward the level-3 memory system
	localparam logic [7:0] LHC_LEN_ONE    = 8'h00;
	localparam logic [7:0] LHC_LEN_SINGLE = 8'h03;
	localparam logic [7:0] LHC_LEN_DOUBLE = 8'h07;
	localparam logic [3:0] LHC_BEATS_LINE = 4'h4;
	localparam logic       LHC_ID_FILL    = 1'b0;
	localparam logic       LHC_ID_SO      = 1'b1;
	// Sizes and forward-progress counts
	localparam int unsigned LHC_AXI_SLOTS  = 4;
	localparam int unsigned LHC_SB_ENTRIES = 4;
	localparam int unsigned LHC_BUF_DEPTH  = 2;
	localparam int unsigned LHC_STARVE_MAX = 16;
	localparam int unsigned LHC_STALL_MAX  = 64;
	// Read request attribute
	typedef enum logic [1:0] {
		LHC_CACHEABLE = 2'b00,
		LHC_NONCACHE  = 2'b01,
		LHC_STRONG    = 2'b10
	} lhc_kind_t;
	// Fill sequencer states
	typedef enum logic [2:0] {
		LHC_S_IDLE    = 3'b000,
		LHC_S_HAZ     = 3'b001,
		LHC_S_LOOK    = 3'b010,
		LHC_S_EVICT1  = 3'b011,
		LHC_S_ISSUE   = 3'b100,
		LHC_S_LOOK2   = 3'b101,
		LHC_S_FILL    = 3'b110,
		LHC_S_EVWAIT2 = 3'b111
	} lhc_state_t;
endpackage
`default_nettype wire

// [core/lhc_read_buf.sv]
// Small valid/ready buffer between the read-data channel and the fill data port
`default_nettype none
module lhc_read_buf import lhc_pkg::*; #(
	parameter int unsigned W     = 66,
	parameter int unsigned DEPTH = LHC_BUF_DEPTH
) (
	input  wire logic         sys_clk,
	input  wire logic         reset,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wp;
		logic [PW-1:0]           rp;
		logic [CW-1:0]           cnt;
	} lhc_buf_t;

	lhc_buf_t buf_reg;
	lhc_buf_t buf_next;
	logic     push;
	logic     pop;

	// Full and empty come straight from the count, so back-pressure is exact
	assign in_ready  = (buf_reg.cnt < CW'(DEPTH));
	assign out_valid = (buf_reg.cnt != '0);
	assign out_data  = buf_reg.mem[buf_reg.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointer and count update
	always_comb begin
		buf_next = buf_reg;
		if (push) begin
			buf_next.mem[buf_reg.wp] = in_data;
			buf_next.wp = (buf_reg.wp == PW'(DEPTH - 1)) ? '0 : PW'(buf_reg.wp + 1'b1);
		end
		if (pop) begin
			buf_next.rp = (buf_reg.rp == PW'(DEPTH - 1)) ? '0 : PW'(buf_reg.rp + 1'b1);
		end
		if (push && !pop) begin
			buf_next.cnt = CW'(buf_reg.cnt + 1'b1);
		end else if (pop && !push) begin
			buf_next.cnt = CW'(buf_reg.cnt - 1'b1);
		end
	end

	// Storage is cleared too so that no unknown ever reaches the port
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			buf_reg <= '0;
		end else begin
			buf_reg <= buf_next;
		end
	end
endmodule
`default_nettype wire

// [core/lhc_ctrl.sv]
// Linefill, eviction pairing, read priority and store-buffer hazard control
// Notes on behaviour
// - Double linefill follows bit 30 of the prefetch control word.
// - Without double fill, a miss fetches one 32-byte line as four 64-bit beats.
// - With double fill, a miss fetches 64 bytes as eight 64-bit beats.
// - During a double fill, look up the second line and pick a victim.
// - A dirty second-half victim is evicted before the second half is allocated.
// - Eviction requests are held until acknowledged, never dropped.
// - Double linefill is off after reset.
// - Priority reads mode follows bit 10 of the auxiliary control word.
// - In priority mode, strongly-ordered reads issue before cacheable fills, until STARVE_MAX wins in a row.
// - The master port allows four outstanding address slots.
// - Priority reads mode is off after reset.
// - Hazard compare uses address bits 31 down to 5.
// - Normal-memory reads wait while a matching store-buffer write is active.
// - A cacheable miss issues a linefill on the master port.
`default_nettype none
module lhc_ctrl import lhc_pkg::*; #(
	parameter int unsigned SLOTS      = LHC_AXI_SLOTS,
	parameter int unsigned SB_N       = LHC_SB_ENTRIES,
	parameter int unsigned STARVE_MAX = LHC_STARVE_MAX,
	parameter int unsigned STALL_MAX  = LHC_STALL_MAX
) (
	input  wire logic                   sys_clk,
	input  wire logic                   reset,
	input  wire logic [LHC_CTRL_W-1:0]  prefetch_ctrl,
	input  wire logic [LHC_CTRL_W-1:0]  aux_ctrl,
	input  wire logic                   rd_valid,
	output logic                        rd_ready,
	input  wire logic [LHC_ADDR_W-1:0]  rd_addr,
	input  wire lhc_kind_t              rd_kind,
	output logic                        rd_done,
	input  wire logic [SB_N-1:0]        sb_valid,
	input  wire logic [SB_N*LHC_LINE_W-1:0] sb_line,
	output logic                        sb_hold,
	output logic                        tag_req,
	output logic [LHC_ADDR_W-1:0]       tag_addr,
	input  wire logic                   tag_hit,
	input  wire logic                   tag_victim_dirty,
	output logic                        ev_valid,
	input  wire logic                   ev_ready,
	output logic                        alloc_valid,
	output logic [LHC_ADDR_W-1:0]       alloc_addr,
	output logic                        m_arvalid,
	input  wire logic                   m_arready,
	output logic [LHC_ADDR_W-1:0]       m_araddr,
	output logic [7:0]                  m_arlen,
	output logic                        m_arid,
	input  wire logic                   m_rvalid,
	output logic                        m_rready,
	input  wire logic [LHC_DATA_W-1:0]  m_rdata,
	input  wire logic                   m_rid,
	input  wire logic                   m_rlast,
	output logic                        fd_valid,
	input  wire logic                   fd_ready,
	output logic [LHC_DATA_W-1:0]       fd_data,
	output logic                        fd_id,
	output logic                        fd_last
);
	localparam int unsigned OW = $clog2(SLOTS + 1);
	localparam int unsigned BW = LHC_DATA_W + 2;

	typedef struct packed {
		lhc_state_t            st;
		logic                  dbl;
		logic                  hp;
		logic                  nc;
		logic                  fdbl;
		logic                  sec_alloc;
		logic                  sec_ev;
		logic [LHC_ADDR_W-1:0] addr;
		logic                  so_v;
		logic [LHC_ADDR_W-1:0] so_addr;
		logic [OW-1:0]         outs;
		logic [3:0]            beats;
		logic [7:0]            starve;
		logic [7:0]            stall;
		logic                  done;
		logic                  alloc_v;
		logic [LHC_ADDR_W-1:0] alloc_a;
	} lhc_ctrl_t;

	lhc_ctrl_t s_reg;
	lhc_ctrl_t s_next;
	logic [SB_N-1:0] hz_hit;
	logic            sb_match;
	logic            fill_want;
	logic            slot_free;
	logic            so_first;
	logic            ar_fire;
	logic            r_fire;
	logic            fill_beat;
	logic            ev_fire;
	logic [BW-1:0]   fd_word;

	// One comparator per store-buffer entry, on the line address only
	for (genvar gi = 0; gi < SB_N; gi++) begin : g_hz
		assign hz_hit[gi] = sb_valid[gi] &&
			(sb_line[gi*LHC_LINE_W +: LHC_LINE_W] == s_reg.addr[LHC_ADDR_W-1:LHC_LINE_LSB]);
	end
	assign sb_match = |hz_hit;

	// Address channel arbitration; a capped counter lets a starved fill win
	assign fill_want = (s_reg.st == LHC_S_ISSUE);
	assign slot_free = (s_reg.outs < OW'(SLOTS));
	assign so_first  = s_reg.so_v &&
		(!fill_want || (s_reg.hp && (s_reg.starve < 8'(STARVE_MAX))));
	assign m_arvalid = slot_free && (s_reg.so_v || fill_want);
	assign m_arid    = so_first ? LHC_ID_SO : LHC_ID_FILL;
	assign m_araddr  = so_first ? s_reg.so_addr : s_reg.addr;
	assign m_arlen   = so_first || s_reg.nc ? LHC_LEN_ONE :
		(s_reg.dbl ? LHC_LEN_DOUBLE : LHC_LEN_SINGLE);
	assign ar_fire   = m_arvalid && m_arready;
	assign r_fire    = m_rvalid && m_rready;
	assign fill_beat = r_fire && (m_rid == LHC_ID_FILL);

	// Eviction request stays up until the buffer takes it
	assign ev_valid = (s_reg.st == LHC_S_EVICT1) || s_reg.sec_ev;
	assign ev_fire  = ev_valid && ev_ready;

	// Tag port serves the first line, then the second half of a double fill
	assign tag_req  = (s_reg.st == LHC_S_LOOK) || (s_reg.st == LHC_S_LOOK2);
	assign tag_addr = (s_reg.st == LHC_S_LOOK2) ? s_reg.addr + LHC_LINE_BYTES : s_reg.addr;

	// Strongly-ordered reads queue in their own entry; normal reads need the sequencer
	assign rd_ready = (rd_kind == LHC_STRONG) ? !s_reg.so_v : (s_reg.st == LHC_S_IDLE);
	assign sb_hold  = (s_reg.st == LHC_S_HAZ) && (s_reg.stall >= 8'(STALL_MAX));
	assign rd_done     = s_reg.done;
	assign alloc_valid = s_reg.alloc_v;
	assign alloc_addr  = s_reg.alloc_a;

	// Next state of the whole controller
	always_comb begin
		s_next = s_reg;
		s_next.done    = 1'b0;
		s_next.alloc_v = 1'b0;
		s_next.dbl = prefetch_ctrl[LHC_DBL_FILL_BIT];
		s_next.hp  = aux_ctrl[LHC_HP_READ_BIT];
		if (rd_valid && rd_ready && (rd_kind == LHC_STRONG)) begin
			s_next.so_v    = 1'b1;
			s_next.so_addr = rd_addr;
		end
		if (ar_fire && so_first) begin
			s_next.so_v = 1'b0;
			if (fill_want && s_reg.starve != 8'hff) begin
				s_next.starve = s_reg.starve + 8'h01;
			end
		end
		// Slot count: one taken per address, one freed per last beat
		if (ar_fire && !(r_fire && m_rlast)) begin
			s_next.outs = OW'(s_reg.outs + 1'b1);
		end else if (!ar_fire && r_fire && m_rlast) begin
			s_next.outs = OW'(s_reg.outs - 1'b1);
		end
		if (fill_beat) begin
			s_next.beats = s_reg.beats + 4'h1;
		end
		if (ev_fire && s_reg.st != LHC_S_EVICT1) begin
			s_next.sec_ev = 1'b0;
		end
		case (s_reg.st)
			LHC_S_IDLE: begin
				if (rd_valid && rd_kind != LHC_STRONG) begin
					s_next.addr  = rd_addr;
					s_next.nc    = (rd_kind == LHC_NONCACHE);
					s_next.stall = 8'h00;
					s_next.st    = LHC_S_HAZ;
				end
			end
			LHC_S_HAZ: begin
				if (!sb_match) begin
					s_next.st = s_reg.nc ? LHC_S_ISSUE : LHC_S_LOOK;
				end else if (s_reg.stall < 8'(STALL_MAX)) begin
					s_next.stall = s_reg.stall + 8'h01;
				end
			end
			LHC_S_LOOK: begin
				if (tag_hit) begin
					s_next.done = 1'b1;
					s_next.st   = LHC_S_IDLE;
				end else if (tag_victim_dirty) begin
					s_next.st = LHC_S_EVICT1;
				end else begin
					s_next.st = LHC_S_ISSUE;
				end
			end
			LHC_S_EVICT1: begin
				if (ev_fire) begin
					s_next.st = LHC_S_ISSUE;
				end
			end
			LHC_S_ISSUE: begin
				if (ar_fire && !so_first) begin
					s_next.starve    = 8'h00;
					s_next.beats     = 4'h0;
					s_next.fdbl      = s_reg.dbl && !s_reg.nc;
					s_next.sec_alloc = 1'b0;
					s_next.st = (s_reg.dbl && !s_reg.nc) ? LHC_S_LOOK2 : LHC_S_FILL;
				end
			end
			LHC_S_LOOK2: begin
				s_next.sec_alloc = !tag_hit;
				s_next.sec_ev    = !tag_hit && tag_victim_dirty;
				s_next.st        = LHC_S_FILL;
			end
			LHC_S_FILL: begin
				// First line is usable after its fourth beat, even in a double fill
				if (fill_beat && !s_reg.nc && (s_next.beats == LHC_BEATS_LINE)) begin
					s_next.alloc_v = 1'b1;
					s_next.alloc_a = s_reg.addr;
					s_next.done    = 1'b1;
				end
				if (fill_beat && m_rlast) begin
					if (s_reg.nc) begin
						s_next.done = 1'b1;
						s_next.st   = LHC_S_IDLE;
					end else if (s_reg.fdbl && s_reg.sec_alloc) begin
						s_next.st = LHC_S_EVWAIT2;
					end else begin
						s_next.st = LHC_S_IDLE;
					end
				end
			end
			LHC_S_EVWAIT2: begin
				if (!s_reg.sec_ev) begin
					s_next.alloc_v = 1'b1;
					s_next.alloc_a = s_reg.addr + LHC_LINE_BYTES;
					s_next.st      = LHC_S_IDLE;
				end
			end
			default: begin
				s_next.st = LHC_S_IDLE;
			end
		endcase
	end

	// All-zero reset leaves both features off and the sequencer idle
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Read data passes a two-entry buffer so a stalled receiver loses no beat
	lhc_read_buf #(
		.W     (BW),
		.DEPTH (LHC_BUF_DEPTH)
	) u_rbuf (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.in_valid  (m_rvalid),
		.in_ready  (m_rready),
		.in_data   ({m_rid, m_rlast, m_rdata}),
		.out_valid (fd_valid),
		.out_ready (fd_ready),
		.out_data  (fd_word)
	);
	assign fd_id   = fd_word[BW-1];
	assign fd_last = fd_word[BW-2];
	assign fd_data = fd_word[LHC_DATA_W-1:0];

	// Checks on the sequencer and the master port
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence dbl_issue_s;
		(s_reg.st == LHC_S_ISSUE) && ar_fire && !so_first && s_reg.dbl && !s_reg.nc;
	endsequence
	sequence second_look_s;
		tag_req && (tag_addr == s_reg.addr + LHC_LINE_BYTES);
	endsequence

	reset_off_a: assert property ($past(reset) |-> !s_reg.dbl && !s_reg.hp)
		else $error("features not off after reset");
	len_single_a: assert property (ar_fire && !so_first && !s_reg.nc && !s_reg.dbl
		|-> m_arlen == LHC_LEN_SINGLE)
		else $error("single fill not four beats");
	len_double_a: assert property (dbl_issue_s |-> m_arlen == LHC_LEN_DOUBLE)
		else $error("double fill not eight beats");
	second_lookup_a: assert property (dbl_issue_s |=> second_look_s)
		else $error("second line not looked up");
	ev_held_a: assert property (ev_valid && !ev_ready |=> ev_valid)
		else $error("eviction request dropped");
	dirty_alloc_a: assert property (s_reg.sec_ev |=> !(alloc_valid &&
		alloc_addr == $past(s_reg.addr) + LHC_LINE_BYTES))
		else $error("second half allocated before eviction");
	slot_limit_a: assert property (s_reg.outs <= OW'(SLOTS))
		else $error("more than four outstanding requests");
	so_priority_a: assert property (fill_want && s_reg.so_v && s_reg.hp && slot_free
		&& (s_reg.starve < 8'(STARVE_MAX)) |-> m_arvalid && m_arid == LHC_ID_SO)
		else $error("priority read not first");
	no_starve_a: assert property (fill_want && slot_free
		&& (s_reg.starve >= 8'(STARVE_MAX)) |-> m_arid == LHC_ID_FILL)
		else $error("fill starved by priority reads");
	hazard_hold_a: assert property ((s_reg.st == LHC_S_HAZ) && sb_match
		|=> s_reg.st == LHC_S_HAZ)
		else $error("read passed a matching write");
	miss_fill_a: assert property ((s_reg.st == LHC_S_LOOK) && !tag_hit && !tag_victim_dirty
		|=> fill_want ##[0:300] m_arvalid)
		else $error("miss did not request a linefill");
endmodule
`default_nettype wire

// [tb/lhc_mem_model.sv]
// Level-3 memory model answering fills and priority reads on the master port
`default_nettype none
module lhc_mem_model import lhc_pkg::*; (
	input  wire logic                  sys_clk,
	input  wire logic                  reset,
	input  wire logic                  slow,
	input  wire logic                  ar_block,
	input  wire logic                  m_arvalid,
	output logic                       m_arready,
	input  wire logic [LHC_ADDR_W-1:0] m_araddr,
	input  wire logic [7:0]            m_arlen,
	input  wire logic                  m_arid,
	output logic                       m_rvalid,
	input  wire logic                  m_rready,
	output logic [LHC_DATA_W-1:0]      m_rdata,
	output logic                       m_rid,
	output logic                       m_rlast
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [LHC_ADDR_W-1:0] qa[$];
	logic [7:0]            ql[$];
	logic                  qi[$];
	logic [7:0]            beat;
	// Beats carry address and beat number; idle data toggles so stale words never match
	always @(posedge sys_clk) begin
		if (reset) begin
			qa.delete();
			ql.delete();
			qi.delete();
			beat = 8'h00;
			m_arready <= 1'b0;
			m_rvalid <= 1'b0;
			// One driver per output, so known levels come from reset only
			m_rdata <= '0;
			m_rid <= 1'b0;
			m_rlast <= 1'b0;
		end else begin
			if (m_arvalid && m_arready) begin
				qa.push_back(m_araddr);
				ql.push_back(m_arlen);
				qi.push_back(m_arid);
			end
			if (m_rvalid && m_rready) begin
				if (beat == ql[0]) begin
					void'(qa.pop_front());
					void'(ql.pop_front());
					void'(qi.pop_front());
					beat = 8'h00;
				end else beat++;
			end
			m_arready <= !ar_block && (!slow || $urandom_range(1, 0) == 1);
			// Valid beat held until the controller takes it
			if (!m_rvalid || m_rready) begin
				if (qa.size() > 0 && (!slow || $urandom_range(3, 0) == 0)) begin
					m_rvalid <= 1'b1;
					m_rdata <= {qa[0], 24'h000000, beat};
					m_rid <= qi[0];
					m_rlast <= (beat == ql[0]);
				end else begin
					m_rvalid <= 1'b0;
					m_rdata <= ~m_rdata;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [tb/test_l2_cache_linefill_hazard_ctrl.sv]
// Self-checking bench for the linefill, eviction, priority and hazard controller
`default_nettype none
module test_l2_cache_linefill_hazard_ctrl import lhc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0, reset = 1'b1, rd_valid = 1'b0, slow = 1'b0, ar_block = 1'b0;
	logic [31:0] prefetch_ctrl = '0, aux_ctrl = '0, rd_addr = '0, cur_addr = '0;
	lhc_kind_t rd_kind = LHC_CACHEABLE;
	logic [3:0] sb_valid = '0, ev_cnt = '0, ev_delay = '0;
	logic [107:0] sb_line = '0;
	logic ev_ready = 1'b0, fd_ready = 1'b0, hit1 = 1'b0, d1 = 1'b0, hit2 = 1'b0, d2 = 1'b0;
	logic rd_ready, rd_done, sb_hold, tag_req, tag_hit, tag_victim_dirty, ev_valid;
	logic alloc_valid, m_arvalid, m_arready, m_arid, m_rvalid, m_rready, m_rid, m_rlast;
	logic fd_valid, fd_id, fd_last, took = 1'b0, ev_pend = 1'b0;
	logic [31:0] tag_addr, alloc_addr, m_araddr;
	logic [7:0] m_arlen;
	logic [63:0] m_rdata, fd_data;
	logic [63:0] fdq[$];
	logic [1:0] fdf[$];
	logic [31:0] alq[$];
	logic [40:0] arq[$];
	int num_errors = 0, checks = 0, ev_taken = 0, seen2 = 0, done_cnt = 0, i, k;
	logic [31:0] a;
	lhc_ctrl #(.STARVE_MAX(2), .STALL_MAX(4)) lhc_ctrl_inst (.sys_clk, .reset, .prefetch_ctrl,
		.aux_ctrl, .rd_valid, .rd_ready, .rd_addr, .rd_kind, .rd_done, .sb_valid, .sb_line,
		.sb_hold, .tag_req, .tag_addr, .tag_hit, .tag_victim_dirty, .ev_valid, .ev_ready,
		.alloc_valid, .alloc_addr, .m_arvalid, .m_arready, .m_araddr, .m_arlen, .m_arid,
		.m_rvalid, .m_rready, .m_rdata, .m_rid, .m_rlast, .fd_valid, .fd_ready, .fd_data,
		.fd_id, .fd_last);
	lhc_mem_model lhc_mem_model_inst (.sys_clk, .reset, .slow, .ar_block, .m_arvalid,
		.m_arready, .m_araddr, .m_arlen, .m_arid, .m_rvalid, .m_rready, .m_rdata, .m_rid,
		.m_rlast);
	always #5 sys_clk = ~sys_clk;
	// Tag array answers the first line and the neighbour line separately
	assign tag_hit = (tag_addr[31:5] == cur_addr[31:5]) ? hit1 : hit2;
	assign tag_victim_dirty = (tag_addr[31:5] == cur_addr[31:5]) ? d1 : d2;
	// Eviction buffer answers late; fill data port stalls at random to fill the buffer
	always @(posedge sys_clk) begin
		ev_cnt <= ev_valid ? ev_cnt + 4'h1 : 4'h0;
		ev_ready <= ev_valid && ev_cnt == ev_delay;
		fd_ready <= $urandom_range(1, 0) == 1;
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	// Monitors sample at the falling edge, where everything has settled
	always @(negedge sys_clk) if (!reset) begin
		if (fd_valid && fd_ready) begin
			fdq.push_back(fd_data);
			fdf.push_back({fd_id, fd_last});
		end
		if (alloc_valid) begin
			alq.push_back(alloc_addr);
			chk(64'(ev_taken >= ((alloc_addr[31:5] == cur_addr[31:5]) ? d1 : d1 + d2)), 1);
		end
		if (m_arvalid && m_arready) arq.push_back({m_arid, m_arlen, m_araddr});
		if (ev_valid && ev_ready) ev_taken++;
		if (tag_req && tag_addr[31:5] == cur_addr[31:5] + 27'h1) seen2++;
		if (ev_pend && !ev_valid) chk(1, 0);
		ev_pend = ev_valid && !ev_ready;
		if (rd_valid && rd_ready) took = 1'b1;
		if (rd_done) done_cnt++;
	end
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic issue(input logic [31:0] ad, input lhc_kind_t kd);
		int n;
		@(posedge sys_clk);
		took = 1'b0;
		if (kd != LHC_STRONG) cur_addr <= ad;
		rd_addr <= ad;
		rd_kind <= kd;
		rd_valid <= 1'b1;
		for (n = 0; n < 300 && !took; n++) @(posedge sys_clk);
		rd_valid <= 1'b0;
		if (!took) begin
			num_errors++;
			complete_run();
		end
	endtask
	// Bounded wait for fill beats, allocations and completions
	task automatic await(input int nf, input int na, input int nd);
		int n;
		for (n = 0; n < 900 && (fdq.size() < nf || alq.size() < na || done_cnt < nd); n++)
			@(posedge sys_clk);
		repeat (4) @(posedge sys_clk);
		if (n == 900) begin
			num_errors++;
			complete_run();
		end
	endtask
	task automatic fill(input logic [31:0] ad, input logic [3:0] tv, input lhc_kind_t kd);
		@(posedge sys_clk);
		fdq.delete();
		fdf.delete();
		alq.delete();
		arq.delete();
		{ev_taken, seen2, done_cnt} = '0;
		{hit1, d1, hit2, d2} <= tv;
		ev_delay <= 4'($urandom_range(7, 0));
		issue(ad, kd);
	endtask
	task automatic check_beats(input logic [31:0] ad, input int nb, input logic [7:0] len);
		chk(arq[0][40:32], {LHC_ID_FILL, len});
		chk(arq[0][31:5], ad[31:5]);
		for (int b = 0; b < nb; b++) begin
			chk(fdq[b][63:37], ad[31:5]);
			chk(fdq[b][7:0], 64'(b));
			chk(fdf[b], {LHC_ID_FILL, b == nb - 1});
		end
	endtask
	initial begin
		void'($urandom(7));
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		@(negedge sys_clk);
		chk({rd_ready, m_arvalid, fd_valid, sb_hold, ev_valid, m_rready}, 6'b100001);
		// Hits: no traffic toward memory
		for (i = 0; i < 4; i++) begin
			fill($urandom, 4'b1000, LHC_CACHEABLE);
			await(0, 0, 1);
			chk(64'(arq.size() + alq.size()), 0);
		end
		$display("hit test done");
		// Single misses, some with a dirty victim, memory fast or slow
		for (i = 0; i < 6; i++) begin
			a = $urandom;
			slow <= 1'(i);
			fill(a, {1'b0, i[1], 2'b00}, LHC_CACHEABLE);
			await(4, 1, 1);
			check_beats(a, 4, LHC_LEN_SINGLE);
			chk(alq[0][31:5], a[31:5]);
			chk(64'(ev_taken), 64'(i[1]));
		end
		slow <= 1'b0;
		$display("single fill test done");
		// Double fills: dirty, hit and clean second line
		prefetch_ctrl <= 32'h1 << LHC_DBL_FILL_BIT;
		for (i = 0; i < 6; i++) begin
			a = $urandom;
			k = i % 3;
			fill(a, {2'b00, k == 1, k == 0}, LHC_CACHEABLE);
			await(8, (k == 1) ? 1 : 2, 1);
			check_beats(a, 8, LHC_LEN_DOUBLE);
			chk(64'(seen2 > 0), 1);
			chk(64'(ev_taken), 64'(k == 0));
			chk(64'(alq.size()), (k == 1) ? 1 : 2);
			if (k != 1) chk(alq[1][31:5], a[31:5] + 27'h1);
		end
		prefetch_ctrl <= '0;
		$display("double fill test done");
		// Read stalled by a matching store, a neighbour line must not match
		a = $urandom;
		sb_line <= {27'h0, a[31:5], a[31:5] ^ 27'h1, 27'h0};
		sb_valid <= 4'b0110;
		fill(a ^ 32'h1f, 4'b0000, LHC_NONCACHE);
		repeat (8) @(posedge sys_clk);
		chk(64'(done_cnt + arq.size()), 0);
		chk(sb_hold, 1);
		sb_valid <= 4'b0010;
		await(1, 0, 1);
		chk(arq[0][40:32], {LHC_ID_FILL, LHC_LEN_ONE});
		chk({sb_hold, 32'(alq.size())}, 0);
		sb_valid <= '0;
		$display("hazard test done");
		// Priority reads against a waiting fill, mode off then on
		for (i = 0; i < 2; i++) begin
			aux_ctrl <= 32'(i) << LHC_HP_READ_BIT;
			ar_block <= 1'b1;
			fill($urandom, 4'b0000, LHC_CACHEABLE);
			repeat (3) @(posedge sys_clk);
			issue($urandom, LHC_STRONG);
			repeat (3) @(negedge sys_clk);
			chk({m_arvalid, m_arid}, {1'b1, i[0]});
			@(posedge sys_clk);
			ar_block <= 1'b0;
			await(5, 1, 1);
			chk({arq[0][40], 32'(arq.size())}, {i[0], 32'd2});
		end
		// Two priority wins while a fill waits, then the starved fill must go first
		ar_block <= 1'b1;
		fill($urandom, 4'b0000, LHC_CACHEABLE);
		for (k = 0; k < 3; k++) begin
			issue($urandom, LHC_STRONG);
			repeat (2) @(posedge sys_clk);
			ar_block <= 1'b0;
			@(posedge sys_clk);
			ar_block <= 1'b1;
			repeat (3) @(posedge sys_clk);
		end
		ar_block <= 1'b0;
		await(7, 1, 1);
		chk({arq[1][40], arq[2][40], 32'(arq.size())}, {2'b10, 32'd4});
		$display("priority test done");
		complete_run();
	end
endmodule
`default_nettype wire
